/* File: logic/clock_stop_pkg.sv */
// Overview of operation
// - sample five strap pins during power-up
// - after reset, strap pins become driven clocks
// - high strap latches one, low latches zero
// - graphics clocks stop low, restart full pulse
// - graphics stop under three periods, restart one
// - graphics stop honoured only with mode strap low
// - other clock groups keep running undisturbed
// - processor clocks stop low, restart full pulse
// - processor stop and restart under four periods
// - all stop inputs synchronized to the input clock clk
// - power-down synchronized before shutdown begins
// - power-down drives all clocks low, oscillators off
// - power-up wait of three milliseconds after sync
// - power-down ignores bus and processor stops
// - reference and 48 MHz stop low quickly
// - outputs go low on next falling edge
// - bus clocks stop low, restart full pulse
// - bus stop within one period, restart next rise
package clock_stop_pkg;
  localparam int STRAP_W        = 5;
  localparam int MODE_BIT       = 0;
  localparam int CLK_PERIOD_NS  = 10;
  localparam int PWRUP_MS       = 3;
  localparam int PWRUP_CYC      = PWRUP_MS * 1000000 / CLK_PERIOD_NS;
  localparam int DIV_HALF       = 2;
  localparam logic [4:0] STRAP_RST = 5'h00;

  typedef struct packed {
    logic processor;
    logic graphics;
    logic bus;
    logic reference;
    logic usb48;
  } clk_group_t;

  typedef struct packed {
    logic graphics_clock_halt_n;
    logic processor_halt_n;
    logic bus_halt_n;
    logic power_down_n;
  } stop_req_t;
endpackage

/* File: logic/clock_output_stop_control.sv */
`timescale 1ns/100ps
`default_nettype none
module clock_output_stop_control #(
  parameter int PWRUP_CYCLES = clock_stop_pkg::PWRUP_CYC,
  parameter int DIV          = clock_stop_pkg::DIV_HALF
) (
  input  wire logic                          clk,
  input  wire logic                          resetn,
  input  wire clock_stop_pkg::stop_req_t     stop_in,
  input  wire logic [clock_stop_pkg::STRAP_W-1:0] strap_pin_in,
  output logic [clock_stop_pkg::STRAP_W-1:0] strap_pin_out,
  output logic [clock_stop_pkg::STRAP_W-1:0] strap_pin_oe,
  output logic [clock_stop_pkg::STRAP_W-1:0] strap_value,
  output clock_stop_pkg::clk_group_t         clk_out,
  output logic                               osc_enable,
  output logic                               clocks_ready
);
  import clock_stop_pkg::*;

  typedef enum logic [1:0] {ST_RUN, ST_DRAIN, ST_DOWN, ST_WAKE} pd_state_t;

  // two-flop synchronizers for async pins
  stop_req_t                  sync1_q;
  stop_req_t                  sync2_q;
  logic [STRAP_W-1:0]         strap_s1_q;
  logic [STRAP_W-1:0]         strap_s2_q;
  logic                       strap_done_q;
  logic [STRAP_W-1:0]         strap_q;
  pd_state_t                  pd_q;
  logic [31:0]                wake_cnt_q;
  logic [7:0]                 div_q;
  logic                       phase_q;
  logic                       en_cpu_q;
  logic                       en_gfx_q;
  logic                       en_bus_q;
  logic                       en_aux_q;
  clk_group_t                 clk_q;
  logic                       rise;
  logic                       fall;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      sync1_q <= '1;
      sync2_q <= '1;
    end else begin
      sync1_q <= stop_in;
      sync2_q <= sync1_q;
    end
  end

  // strap capture while reset is held, then pins turn to outputs
  always_ff @(posedge clk) begin
    strap_s1_q <= strap_pin_in;
    strap_s2_q <= strap_s1_q;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      strap_done_q <= 1'b0;
      strap_q      <= STRAP_RST;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      strap_q      <= strap_s2_q;
    end
  end

  assign strap_value = strap_q;

  // internal processor clock phase
  always_ff @(posedge clk) begin
    if (!resetn) begin
      div_q   <= 8'h00;
      phase_q <= 1'b0;
    end else if (div_q == 8'(DIV - 1)) begin
      div_q   <= 8'h00;
      phase_q <= ~phase_q;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  assign rise = (div_q == 8'(DIV - 1)) && !phase_q;
  assign fall = (div_q == 8'(DIV - 1)) && phase_q;

  // power-down sequencing
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pd_q       <= ST_RUN;
      wake_cnt_q <= 32'h0;
    end else begin
      case (pd_q)
        ST_RUN: begin
          if (!sync2_q.power_down_n) pd_q <= ST_DRAIN;
        end
        ST_DRAIN: begin
          if (fall) pd_q <= ST_DOWN;
        end
        ST_DOWN: begin
          wake_cnt_q <= 32'h0;
          if (sync2_q.power_down_n) pd_q <= ST_WAKE;
        end
        ST_WAKE: begin
          if (!sync2_q.power_down_n) begin
            pd_q <= ST_DRAIN;
          end else if (wake_cnt_q == 32'(PWRUP_CYCLES - 1)) begin
            pd_q <= ST_RUN;
          end else begin
            wake_cnt_q <= wake_cnt_q + 32'h1;
          end
        end
        default: pd_q <= ST_RUN;
      endcase
    end
  end

  // per-group enables change only on falling edge, so stop is low and
  // restart yields a full high pulse
  always_ff @(posedge clk) begin
    if (!resetn) begin
      en_cpu_q <= 1'b1;
      en_gfx_q <= 1'b1;
      en_bus_q <= 1'b1;
      en_aux_q <= 1'b1;
    end else if (fall) begin
      if (pd_q != ST_RUN) begin
        en_cpu_q <= 1'b0;
        en_gfx_q <= 1'b0;
        en_bus_q <= 1'b0;
        en_aux_q <= 1'b0;
      end else begin
        en_cpu_q <= sync2_q.processor_halt_n;
        en_gfx_q <= sync2_q.graphics_clock_halt_n || strap_q[MODE_BIT];
        en_bus_q <= sync2_q.bus_halt_n;
        en_aux_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      clk_q <= '0;
    end else if (rise) begin
      clk_q.processor <= en_cpu_q;
      clk_q.graphics  <= en_gfx_q;
      clk_q.bus       <= en_bus_q;
      clk_q.reference <= en_aux_q;
      clk_q.usb48     <= en_aux_q;
    end else if (fall) begin
      clk_q <= '0;
    end
  end

  assign clk_out       = clk_q;
  assign osc_enable    = (pd_q != ST_DOWN);
  assign clocks_ready  = (pd_q == ST_RUN);
  assign strap_pin_oe  = {STRAP_W{strap_done_q}};
  assign strap_pin_out = {STRAP_W{clk_q.bus}};

  chk_gfx_mode_ignored: assert property (@(posedge clk) disable iff (!resetn)
    (strap_q[MODE_BIT] && pd_q == ST_RUN && fall)
      |=> en_gfx_q)
    else $error("graphics stop not ignored with mode high");
  chk_cpu_stop_lat: assert property (@(posedge clk) disable iff (!resetn)
    (!sync2_q.processor_halt_n && pd_q == ST_RUN && fall) |=> !en_cpu_q)
    else $error("processor enable not cleared");
  chk_stop_low: assert property (@(posedge clk) disable iff (!resetn)
    (!en_gfx_q && $past(!en_gfx_q)) |-> !clk_q.graphics)
    else $error("graphics clock not held low");
  chk_bus_low: assert property (@(posedge clk) disable iff (!resetn)
    (!en_bus_q && $past(!en_bus_q)) |-> !clk_q.bus)
    else $error("bus clock not held low");
  chk_pd_fall: assert property (@(posedge clk) disable iff (!resetn)
    (pd_q == ST_DRAIN && fall) |=> (pd_q == ST_DOWN))
    else $error("power-down not entered on falling edge");
  chk_pd_all_low: assert property (@(posedge clk) disable iff (!resetn)
    (pd_q == ST_DOWN) |-> (clk_q == '0 && !en_cpu_q && !en_aux_q))
    else $error("clocks not low in power-down");
  chk_pd_sync: assert property (@(posedge clk) disable iff (!resetn)
    (pd_q == ST_RUN && $fell(sync2_q.power_down_n)) |=> (pd_q == ST_DRAIN))
    else $error("power-down request not taken");
  chk_strap_oe: assert property (@(posedge clk) disable iff (!resetn)
    $rose(strap_done_q) |-> (strap_pin_oe == '1 && strap_q == $past(strap_s2_q)))
    else $error("strap capture or pin turnaround wrong");
  chk_pd_ignores: assert property (@(posedge clk) disable iff (!resetn)
    (pd_q == ST_DOWN && fall) |=> (!en_cpu_q && !en_bus_q))
    else $error("stop inputs honoured during power-down");
  chk_aux_runs: assert property (@(posedge clk) disable iff (!resetn)
    (pd_q == ST_RUN && $past(pd_q) == ST_RUN && fall) |=> en_aux_q)
    else $error("free clocks disturbed");

  // input synchronizer stages
  chk_sync_first: assert property (@(posedge clk) disable iff (!resetn)
    $past(resetn)
      |-> (sync1_q == $past(stop_in)))
    else $error("first sync stage does not follow pins");

  chk_sync_second: assert property (@(posedge clk) disable iff (!resetn)
    $past(resetn)
      |-> (sync2_q == $past(sync1_q)))
    else $error("second sync stage does not follow first");

  chk_div_range: assert property (@(posedge clk) disable iff (!resetn)
    div_q <= 8'(DIV - 1))
    else $error("internal clock divider out of range");

  // strap latch and pin turnaround
  chk_strap_hold: assert property (@(posedge clk) disable iff (!resetn)
    (strap_done_q && $past(strap_done_q))
      |-> $stable(strap_q))
    else $error("strap latch changed after capture");

  chk_oe_before: assert property (@(posedge clk) disable iff (!resetn)
    !strap_done_q
      |-> (strap_pin_oe == '0))
    else $error("strap pins driven before capture");

  // per-group enable decisions at the internal falling point
  chk_gfx_stop: assert property (@(posedge clk) disable iff (!resetn)
    (!sync2_q.graphics_clock_halt_n && !strap_q[MODE_BIT] && pd_q == ST_RUN && fall)
      |=> !en_gfx_q)
    else $error("graphics stop not honoured with mode low");

  chk_gfx_start: assert property (@(posedge clk) disable iff (!resetn)
    (sync2_q.graphics_clock_halt_n && pd_q == ST_RUN && fall)
      |=> en_gfx_q)
    else $error("graphics clock not restarted");

  chk_cpu_start: assert property (@(posedge clk) disable iff (!resetn)
    (sync2_q.processor_halt_n && pd_q == ST_RUN && fall)
      |=> en_cpu_q)
    else $error("processor clock not restarted");

  chk_bus_stop: assert property (@(posedge clk) disable iff (!resetn)
    (!sync2_q.bus_halt_n && pd_q == ST_RUN && fall)
      |=> !en_bus_q)
    else $error("bus enable not cleared");

  chk_bus_start: assert property (@(posedge clk) disable iff (!resetn)
    (sync2_q.bus_halt_n && pd_q == ST_RUN && fall)
      |=> en_bus_q)
    else $error("bus clock not restarted");

  // full first high pulse after every restart
  chk_pulse_cpu: assert property (@(posedge clk) disable iff (!resetn)
    $rose(clk_q.processor)
      |=> clk_q.processor)
    else $error("processor high pulse cut short");

  chk_pulse_gfx: assert property (@(posedge clk) disable iff (!resetn)
    $rose(clk_q.graphics)
      |=> clk_q.graphics)
    else $error("graphics high pulse cut short");

  chk_pulse_bus: assert property (@(posedge clk) disable iff (!resetn)
    $rose(clk_q.bus)
      |=> clk_q.bus)
    else $error("bus high pulse cut short");

  chk_pulse_ref: assert property (@(posedge clk) disable iff (!resetn)
    $rose(clk_q.reference)
      |=> clk_q.reference)
    else $error("reference high pulse cut short");

  chk_cpu_low: assert property (@(posedge clk) disable iff (!resetn)
    (!en_cpu_q && $past(!en_cpu_q))
      |-> !clk_q.processor)
    else $error("processor clock not held low");

  // stop and restart latency
  chk_gfx_restart: assert property (@(posedge clk) disable iff (!resetn)
    $rose(en_gfx_q)
      |-> ##[1:2] clk_q.graphics)
    else $error("graphics restart too slow");

  chk_cpu_restart: assert property (@(posedge clk) disable iff (!resetn)
    $rose(en_cpu_q)
      |-> ##[1:2] clk_q.processor)
    else $error("processor restart too slow");

  chk_bus_restart: assert property (@(posedge clk) disable iff (!resetn)
    $rose(en_bus_q)
      |-> ##[1:2] clk_q.bus)
    else $error("bus restart too slow");

  chk_gfx_off: assert property (@(posedge clk) disable iff (!resetn)
    $fell(en_gfx_q)
      |-> !clk_q.graphics)
    else $error("graphics clock high after stop");

  chk_cpu_off: assert property (@(posedge clk) disable iff (!resetn)
    $fell(en_cpu_q)
      |-> !clk_q.processor)
    else $error("processor clock high after stop");

  chk_bus_off: assert property (@(posedge clk) disable iff (!resetn)
    $fell(en_bus_q)
      |-> !clk_q.bus)
    else $error("bus clock high after stop");

  // power-down sequence
  chk_osc_low_clk: assert property (@(posedge clk) disable iff (!resetn)
    !osc_enable
      |-> (clk_q == '0))
    else $error("clock high while oscillator off");

  chk_stay_down: assert property (@(posedge clk) disable iff (!resetn)
    (pd_q == ST_DOWN && !sync2_q.power_down_n)
      |=> (pd_q == ST_DOWN))
    else $error("left power-down while still requested");

  chk_wake_abort: assert property (@(posedge clk) disable iff (!resetn)
    (pd_q == ST_WAKE && !sync2_q.power_down_n)
      |=> (pd_q == ST_DRAIN))
    else $error("new power-down during wake not taken");

  chk_wake_done: assert property (@(posedge clk) disable iff (!resetn)
    (pd_q == ST_WAKE && sync2_q.power_down_n && wake_cnt_q == 32'(PWRUP_CYCLES - 1))
      |=> clocks_ready)
    else $error("wake count ended without ready");

  chk_wake_bound: assert property (@(posedge clk) disable iff (!resetn)
    wake_cnt_q < 32'(PWRUP_CYCLES))
    else $error("wake counter past its limit");

  chk_drain_bound: assert property (@(posedge clk) disable iff (!resetn)
    (pd_q == ST_DRAIN && $past(pd_q) == ST_RUN)
      |-> ##[1:4] (pd_q != ST_DRAIN))
    else $error("drain lasted past one internal period");

  chk_drain_clear: assert property (@(posedge clk) disable iff (!resetn)
    (pd_q == ST_DRAIN && fall)
      |=> (!en_aux_q && !en_bus_q && !en_cpu_q && !en_gfx_q && !clk_q.reference))
    else $error("enables not cleared on power-down");

  cov_gfx_stop: cover property (@(posedge clk) disable iff (!resetn) $fell(en_gfx_q));
  cov_cpu_stop: cover property (@(posedge clk) disable iff (!resetn) $fell(en_cpu_q));
  cov_bus_stop: cover property (@(posedge clk) disable iff (!resetn) $fell(en_bus_q));
  cov_wake: cover property (@(posedge clk) disable iff (!resetn)
    (pd_q == ST_WAKE) ##1 (pd_q == ST_RUN));
  cov_pd_down: cover property (@(posedge clk) disable iff (!resetn)
    (pd_q == ST_DRAIN) ##1 (pd_q == ST_DOWN));
endmodule
`default_nettype wire

/* File: tb/chipset_model.sv */
`timescale 1ns/100ps
`default_nettype none
module chipset_model #(
  parameter int MIN_REL = 40
) (
  input  wire logic                      clk,
  input  wire logic                      resetn,
  input  wire clock_stop_pkg::stop_req_t want,
  output clock_stop_pkg::stop_req_t      drive
);
  import clock_stop_pkg::*;
  int rel_q;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      drive <= '1;
      rel_q <= 0;
    end else begin
      drive.graphics_clock_halt_n <= want.graphics_clock_halt_n;
      drive.processor_halt_n      <= want.processor_halt_n;
      drive.power_down_n          <= want.power_down_n;
      rel_q                       <= drive.bus_halt_n ? rel_q + 1 : 0;
      // a bus stop waits until the bus clocks have run long enough
      drive.bus_halt_n <= want.bus_halt_n || (drive.bus_halt_n && rel_q < MIN_REL);
    end
  end
endmodule
`default_nettype wire

/* File: tb/clock_output_stop_control_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module clock_output_stop_control_tb;
  import clock_stop_pkg::*;
  localparam int PW = 20;
  logic       clk = 0;
  logic       resetn = 0;
  stop_req_t  want = '1;
  stop_req_t  stop_in;
  logic [4:0] pull = 5'h1e;
  logic [4:0] pin;
  logic [4:0] pin_out;
  logic [4:0] pin_oe;
  logic [4:0] strap;
  clk_group_t co;
  logic       osc;
  logic       rdy;
  int         err_count = 0;
  int         cmp_count = 0;
  // strap resistors show on the pin only while it is not driven
  assign pin = (pin_oe & pin_out) | (~pin_oe & pull);
  initial forever #5 clk = ~clk;
  chipset_model u_chipset_model (.clk(clk), .resetn(resetn), .want(want), .drive(stop_in));
  clock_output_stop_control #(.PWRUP_CYCLES(PW)) u_clock_output_stop_control (
    .clk(clk), .resetn(resetn), .stop_in(stop_in), .strap_pin_in(pin),
    .strap_pin_out(pin_out), .strap_pin_oe(pin_oe), .strap_value(strap),
    .clk_out(co), .osc_enable(osc), .clocks_ready(rdy));
  task check(input logic [4:0] got, input logic [4:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task seen(input int n, output logic [4:0] hi);
    hi = '0;
    repeat (n) begin
      tick(1);
      hi = hi | co;
    end
  endtask
  task do_reset(input logic [4:0] p);
    pull = p;
    want = '1;
    resetn = 0;
    tick(20);
    resetn = 1;
    tick(2);
    check(strap, p);
    check(pin_oe, 5'h1f);
    check(pin_out, {5{co[2]}});
  endtask
  task stop_grp(input int sb, input int g, input logic on, input int lim);
    logic [4:0] hi;
    logic [4:0] exp;
    int         i;
    exp = 5'h1f;
    exp[g] = !on;
    want[sb] = 0;
    tick(20);
    seen(16, hi);
    check(hi, exp);
    want[sb] = 1;
    hi = co;
    i = 0;
    while (!(co[g] && !hi[g]) && i < lim) begin
      hi = co;
      tick(1);
      i++;
    end
    check({4'h0, co[g]}, 5'h01);
    tick(1);
    check({4'h0, co[g]}, 5'h01);
  endtask
  task power_down;
    logic [4:0] hi;
    int         i;
    want.power_down_n = 0;
    tick(10);
    seen(16, hi);
    check(hi, 5'h00);
    check({3'h0, osc, rdy}, 5'h00);
    want.power_down_n = 1;
    i = 0;
    while (rdy !== 1'b1 && i < PW + 40) begin
      tick(1);
      i++;
    end
    check({4'h0, rdy}, 5'h01);
    seen(16, hi);
    check(hi, 5'h1f);
  endtask
  task report_and_stop;
    $display("mismatches %0d in %0d comparisons", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    do_reset(5'h1e);
    stop_grp(3, 3, 1, 10);
    stop_grp(2, 4, 1, 22);
    stop_grp(1, 2, 1, 22);
    power_down();
    check(strap, 5'h1e);
    do_reset(5'h1f);
    stop_grp(3, 3, 0, 10);
    report_and_stop();
  end
  initial begin
    repeat (6000) @(posedge clk);
    err_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
